// >>> hw/scpmc_consts.svh
`ifndef SCPMC_CONSTS_SVH
`define SCPMC_CONSTS_SVH
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define SCPMC_ADDR_SYS_CLK_CTRL 8'h00
`define SCPMC_ADDR_FAST_OSC_CTRL 8'h04
`define SCPMC_ADDR_POWER_STATUS 8'h08
`define SCPMC_ADDR_PORTA_WAKE 8'h0C
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCPMC_SCC_SEL_LSB 5
`define SCPMC_SCC_FAST_KEEP 1
`define SCPMC_SCC_SLOW_KEEP 0
`define SCPMC_FOC_FREQ_LSB 2
`define SCPMC_FOC_STABLE 1
`define SCPMC_FOC_ENABLE 0
`define SCPMC_PST_PDF 0
`define SCPMC_PST_TO 1
`define SCPMC_PST_MODE_LSB 4
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define SCPMC_SCC_RESET 8'h00
`define SCPMC_FOC_RESET 8'h01
`define SCPMC_SEL_SUB 3'h7
`define SCPMC_FREQ_2M 2'h0
// Oscillator settle times in microseconds and their cycle counts at 20 MHz
`define SCPMC_CLK_MHZ 20
`define SCPMC_FAST_SETTLE_US 16
`define SCPMC_FAST_SETTLE_CYC (`SCPMC_FAST_SETTLE_US * `SCPMC_CLK_MHZ)
`define SCPMC_SLOW_SETTLE_US 8
`define SCPMC_SLOW_SETTLE_CYC (`SCPMC_SLOW_SETTLE_US * `SCPMC_CLK_MHZ)
`endif

// >>> hw/scpmc_ctrl.sv
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "scpmc_consts.svh"

// Operation
// - select field gives fast divided or sub
// - fast keep bit holds fast oscillator in halt
// - slow keep bit holds slow oscillator in halt
// - frequency field picks 2,4,8,2 MHz
// - new frequency applies after stable flag
// - enable clears stable, then sets when settled
// - halt picks sleep or idle by keep bits
// - sleep stops system clock, watchdog runs
// - idle_mode_1 keeps fast and sub clocks
// - idle_mode_2 fast only, idle_mode_0 sub only
// - low power preserves memory, registers, ports
// - halt sets power-down, clears timeout
// - halt clears watchdog, counting continues
// - sub select completes when slow oscillator stable
// - wake on port edge, interrupt, watchdog
// - power-down clears only on power-up, clear-watchdog
// - watchdog wake sets timeout, resets pc/sp
// - masked port falling edge wakes, resumes next
// - disabled or stack-full interrupt defers service
// - enabled interrupt with room gets response
// - interrupt pending before halt cannot wake
// - in slow mode fast follows enable bit
module scpmc_ctrl #(
  parameter int PA_WIDTH = 8,
  parameter int IRQ_WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic halt_exec,
  input wire logic clr_wdt_exec,
  input wire logic wdt_overflow,
  input wire logic [PA_WIDTH-1:0] porta_pins,
  input wire logic [IRQ_WIDTH-1:0] irq_req,
  input wire logic [IRQ_WIDTH-1:0] irq_enable,
  input wire logic stack_full,
  output logic sys_clk_tick,
  output logic fast_osc_run,
  output logic slow_osc_run,
  output logic [1:0] fast_osc_freq,
  output logic cpu_halted,
  output logic wdt_clear,
  output logic wake_resume,
  output logic wake_irq_service,
  output logic wake_wdt_reset
);
  scpmc_pkg::scpmc_state_type r;
  scpmc_pkg::scpmc_state_type next_r;
  logic [7:0] pa_fall;
  logic [7:0] irq_wake;
  logic [7:0] wreg;
  logic low_power;
  logic fast_keep_on;
  logic slow_keep_on;
  logic [2:0] want_sel;

  // ----------------------------------------
  // Bus slave (zero wait, always OKAY)
  // ----------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------
  // Outputs, all from registered state
  // ----------------------------------------
  assign sys_clk_tick = r.sys_tick;
  assign fast_osc_freq = r.applied_freq;
  assign cpu_halted = (r.mode != scpmc_pkg::SCPMC_RUN);
  assign wdt_clear = r.wdt_clear;
  assign wake_resume = r.wake_resume;
  assign wake_irq_service = r.wake_irq_service;
  assign wake_wdt_reset = r.wake_wdt_reset;
  // Oscillators run per mode
  assign fast_osc_run = fast_keep_on;
  assign slow_osc_run = slow_keep_on;

  // Oscillator demand per mode; the watchdog's own slow source lives outside this block
  always_comb begin
    low_power = (r.mode != scpmc_pkg::SCPMC_RUN);
    case (r.mode)
      scpmc_pkg::SCPMC_SLEEP: begin
        fast_keep_on = 1'b0;
        slow_keep_on = 1'b0;
      end
      scpmc_pkg::SCPMC_IDLE_MODE_0: begin
        fast_keep_on = 1'b0;
        slow_keep_on = 1'b1;
      end
      scpmc_pkg::SCPMC_IDLE_MODE_1: begin
        fast_keep_on = 1'b1;
        slow_keep_on = 1'b1;
      end
      scpmc_pkg::SCPMC_IDLE_MODE_2: begin
        fast_keep_on = 1'b1;
        slow_keep_on = 1'b0;
      end
      default: begin
        // In slow mode fast follows its enable
        // A fast code selected or still active pins it on, else the system clock would starve
        fast_keep_on = r.fast_osc_enable || (r.sys_clk_select != `SCPMC_SEL_SUB)
                       || (r.active_sel != `SCPMC_SEL_SUB);
        slow_keep_on = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // Wake sources
  // ----------------------------------------
  always_comb begin
    pa_fall = '0;
    irq_wake = '0;
    pa_fall[PA_WIDTH-1:0] = r.pa_prev[PA_WIDTH-1:0] & ~r.pa_s2[PA_WIDTH-1:0]
                            & r.porta_wake_mask[PA_WIDTH-1:0];
    // Requests already pending at halt are masked out
    irq_wake[IRQ_WIDTH-1:0] = irq_req & ~r.irq_masked[IRQ_WIDTH-1:0];
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_r = r;
    wreg = hwdata[7:0];
    want_sel = r.sys_clk_select;
    next_r.wdt_clear = 1'b0;
    next_r.wake_resume = 1'b0;
    next_r.wake_irq_service = 1'b0;
    next_r.wake_wdt_reset = 1'b0;
    next_r.pa_s1[PA_WIDTH-1:0] = porta_pins;
    next_r.pa_s2 = r.pa_s1;
    next_r.pa_prev = r.pa_s2;

    // Address phase capture
    next_r.ap.valid = hsel & hready & htrans[1];
    next_r.ap.write = hwrite;
    next_r.ap.addr = haddr;

    // Data phase write; stable flag is read-only
    if (r.ap.valid && r.ap.write) begin
      case (r.ap.addr)
        `SCPMC_ADDR_SYS_CLK_CTRL: begin
          next_r.sys_clk_select = wreg[`SCPMC_SCC_SEL_LSB +: 3];
          next_r.fast_osc_halt_keep = wreg[`SCPMC_SCC_FAST_KEEP];
          next_r.slow_osc_halt_keep = wreg[`SCPMC_SCC_SLOW_KEEP];
        end
        `SCPMC_ADDR_FAST_OSC_CTRL: begin
          next_r.fast_osc_freq_sel = wreg[`SCPMC_FOC_FREQ_LSB +: 2];
          next_r.fast_osc_enable = wreg[`SCPMC_FOC_ENABLE];
          // Re-enable or retune restarts settling
          if ((wreg[`SCPMC_FOC_ENABLE] && !r.fast_osc_enable) ||
              (wreg[`SCPMC_FOC_FREQ_LSB +: 2] != r.fast_osc_freq_sel)) begin
            next_r.fast_osc_stable_flag = 1'b0;
            next_r.fast_cnt = '0;
          end
        end
        `SCPMC_ADDR_PORTA_WAKE: next_r.porta_wake_mask = wreg;
        default: ;
      endcase
    end

    // Fast oscillator settle counter
    if (!fast_keep_on) begin
      next_r.fast_osc_stable_flag = 1'b0;
      next_r.fast_cnt = '0;
    end else if (!r.fast_osc_stable_flag && next_r.fast_cnt == r.fast_cnt) begin
      if (r.fast_cnt == 16'(`SCPMC_FAST_SETTLE_CYC - 1)) begin
        next_r.fast_osc_stable_flag = 1'b1;
      end else begin
        next_r.fast_cnt = r.fast_cnt + 16'h0001;
      end
    end
    // New frequency takes effect only once settled
    if (r.fast_osc_stable_flag) begin
      next_r.applied_freq = (r.fast_osc_freq_sel == 2'h3) ? `SCPMC_FREQ_2M
                            : r.fast_osc_freq_sel;
    end

    // Slow oscillator settle
    if (!slow_keep_on) begin
      next_r.slow_stable = 1'b0;
      next_r.slow_cnt = '0;
    end else if (!r.slow_stable) begin
      if (r.slow_cnt == 16'(`SCPMC_SLOW_SETTLE_CYC - 1)) begin
        next_r.slow_stable = 1'b1;
      end else begin
        next_r.slow_cnt = r.slow_cnt + 16'h0001;
      end
    end

    // Source switch waits for target stable, only at a period end
    if (r.active_sel != r.sys_clk_select && r.div_cnt == 6'h00) begin
      if (want_sel == `SCPMC_SEL_SUB ? r.slow_stable : r.fast_osc_stable_flag) begin
        next_r.active_sel = want_sel;
      end
    end

    // Divider gives one tick per 2^sel cycles on fast codes, one every cycle on sub; none in sleep
    next_r.sys_tick = 1'b0;
    if (!low_power) begin
      if (r.active_sel == `SCPMC_SEL_SUB) begin
        next_r.sys_tick = r.slow_stable;
        next_r.div_cnt = '0;
      end else if (r.fast_osc_stable_flag) begin
        if (r.div_cnt >= 6'((7'h01 << r.active_sel) - 7'h01)) begin
          next_r.div_cnt = '0;
          next_r.sys_tick = 1'b1;
        end else begin
          next_r.div_cnt = r.div_cnt + 6'h01;
        end
      end
    end

    // Halt entry; registers simply hold their values
    if (!low_power && halt_exec) begin
      case ({r.fast_osc_halt_keep, r.slow_osc_halt_keep})
        2'b00: next_r.mode = scpmc_pkg::SCPMC_SLEEP;
        2'b01: next_r.mode = scpmc_pkg::SCPMC_IDLE_MODE_0;
        2'b11: next_r.mode = scpmc_pkg::SCPMC_IDLE_MODE_1;
        default: next_r.mode = scpmc_pkg::SCPMC_IDLE_MODE_2;
      endcase
      next_r.power_down_flag = 1'b1;
      next_r.timeout_flag = 1'b0;
      next_r.wdt_clear = 1'b1;
      next_r.irq_masked[IRQ_WIDTH-1:0] = irq_req;
    end else if (low_power) begin
      // Watchdog first, then interrupts, then port edges
      if (wdt_overflow) begin
        next_r.mode = scpmc_pkg::SCPMC_RUN;
        next_r.timeout_flag = 1'b1;
        next_r.wake_wdt_reset = 1'b1;
      end else if (|irq_wake) begin
        next_r.mode = scpmc_pkg::SCPMC_RUN;
        // Service now only if enabled with stack room
        if (|(irq_wake[IRQ_WIDTH-1:0] & irq_enable) && !stack_full) begin
          next_r.wake_irq_service = 1'b1;
        end else begin
          next_r.wake_resume = 1'b1;
        end
      end else if (|pa_fall) begin
        next_r.mode = scpmc_pkg::SCPMC_RUN;
        next_r.wake_resume = 1'b1;
      end
    end

    // Clear-watchdog clears power-down; halt's set wins
    if (clr_wdt_exec && !(!low_power && halt_exec)) begin
      next_r.power_down_flag = 1'b0;
      next_r.wdt_clear = 1'b1;
    end
  end

  // ----------------------------------------
  // State register; power-up clears the flags
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.fast_osc_enable <= 1'(`SCPMC_FOC_RESET);
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Read data, registered in the address phase
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr)
        `SCPMC_ADDR_SYS_CLK_CTRL: hrdata <= {24'h000000, r.sys_clk_select, 3'h0,
                                     r.fast_osc_halt_keep, r.slow_osc_halt_keep};
        `SCPMC_ADDR_FAST_OSC_CTRL: hrdata <= {28'h0000000, r.fast_osc_freq_sel,
                                      r.fast_osc_stable_flag, r.fast_osc_enable};
        `SCPMC_ADDR_POWER_STATUS: hrdata <= {25'h0000000, r.mode, 2'h0,
                                     r.timeout_flag, r.power_down_flag};
        `SCPMC_ADDR_PORTA_WAKE: hrdata <= {24'h000000, r.porta_wake_mask};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions and covers
  // ----------------------------------------
  a_halt_sets_pdf: assert property (@(posedge clk) disable iff (!rst_b)
    (!cpu_halted && halt_exec) |=> (r.power_down_flag && !r.timeout_flag && wdt_clear))
    else $error("halt did not set pdf");
  a_sleep_mode_sel: assert property (@(posedge clk) disable iff (!rst_b)
    (!cpu_halted && halt_exec && !r.fast_osc_halt_keep && !r.slow_osc_halt_keep)
    |=> r.mode == scpmc_pkg::SCPMC_SLEEP)
    else $error("wrong mode on halt");
  a_sleep_no_tick: assert property (@(posedge clk) disable iff (!rst_b)
    (r.mode == scpmc_pkg::SCPMC_SLEEP) |=> !sys_clk_tick)
    else $error("tick in sleep");
  a_idle_mode_1_osc_on: assert property (@(posedge clk) disable iff (!rst_b)
    (r.mode == scpmc_pkg::SCPMC_IDLE_MODE_1) |-> (fast_osc_run && slow_osc_run))
    else $error("idle_mode_1 oscillator off");
  a_idle_mode_0_fast_off: assert property (@(posedge clk) disable iff (!rst_b)
    (r.mode == scpmc_pkg::SCPMC_IDLE_MODE_0) |-> (!fast_osc_run && slow_osc_run))
    else $error("idle_mode_0 oscillators wrong");
  a_wdt_wake_to: assert property (@(posedge clk) disable iff (!rst_b)
    (cpu_halted && wdt_overflow) |=> (wake_wdt_reset && r.timeout_flag && !cpu_halted))
    else $error("watchdog wake wrong");
  a_pdf_hold: assert property (@(posedge clk) disable iff (!rst_b)
    ($fell(r.power_down_flag)) |-> $past(clr_wdt_exec))
    else $error("pdf cleared without clr");
  a_enable_clears_flag: assert property (@(posedge clk) disable iff (!rst_b)
    (r.ap.valid && r.ap.write && r.ap.addr == `SCPMC_ADDR_FAST_OSC_CTRL
     && hwdata[`SCPMC_FOC_ENABLE] && !r.fast_osc_enable) |=> !r.fast_osc_stable_flag)
    else $error("stable flag not cleared");
  a_irq_service: assert property (@(posedge clk) disable iff (!rst_b)
    (cpu_halted && !wdt_overflow && |(irq_wake[IRQ_WIDTH-1:0] & irq_enable) && !stack_full)
    |=> wake_irq_service)
    else $error("interrupt not serviced");
  // Settling, source switching, oscillator demand and frequency hand-over
  a_settle_count_end: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(r.fast_osc_stable_flag) |-> (r.fast_cnt == 16'(`SCPMC_FAST_SETTLE_CYC - 1)))
    else $error("stable flag set early");
  a_sub_switch_stable: assert property (@(posedge clk) disable iff (!rst_b)
    ($changed(r.active_sel) && r.active_sel == `SCPMC_SEL_SUB) |-> $past(r.slow_stable))
    else $error("sub switch before stable");
  a_freq_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !r.fast_osc_stable_flag |=> $stable(fast_osc_freq))
    else $error("frequency applied while unstable");
  a_idle_mode_2_sub_off: assert property (@(posedge clk) disable iff (!rst_b)
    (r.mode == scpmc_pkg::SCPMC_IDLE_MODE_2) |-> (fast_osc_run && !slow_osc_run))
    else $error("idle_mode_2 oscillators wrong");
  a_slow_fast_follow: assert property (@(posedge clk) disable iff (!rst_b)
    (!cpu_halted && r.active_sel == `SCPMC_SEL_SUB && r.sys_clk_select == `SCPMC_SEL_SUB)
    |-> (fast_osc_run == r.fast_osc_enable))
    else $error("fast oscillator ignores enable");
  // Wake-up paths and status flags
  a_port_wake: assert property (@(posedge clk) disable iff (!rst_b)
    (cpu_halted && !wdt_overflow && irq_wake == 8'h00 && |pa_fall) |=> (wake_resume && !cpu_halted))
    else $error("port edge did not wake");
  a_irq_defer: assert property (@(posedge clk) disable iff (!rst_b)
    (cpu_halted && !wdt_overflow && |irq_wake
     && (stack_full || !(|(irq_wake[IRQ_WIDTH-1:0] & irq_enable)))) |=> wake_resume)
    else $error("deferred interrupt not resumed");
  a_pending_masked: assert property (@(posedge clk) disable iff (!rst_b)
    (!cpu_halted && halt_exec) |=> (r.irq_masked[IRQ_WIDTH-1:0] == $past(irq_req)))
    else $error("pending request not masked");
  a_clr_clears_pdf: assert property (@(posedge clk) disable iff (!rst_b)
    (clr_wdt_exec && !(!cpu_halted && halt_exec)) |=> !r.power_down_flag)
    else $error("clear-watchdog left pdf set");
  c_idle_wake: cover property (@(posedge clk) disable iff (!rst_b)
    r.mode == scpmc_pkg::SCPMC_IDLE_MODE_2 ##[1:50] wake_resume);
  c_irq_service: cover property (@(posedge clk) disable iff (!rst_b) wake_irq_service);
  c_wdt_wake: cover property (@(posedge clk) disable iff (!rst_b) wake_wdt_reset);
  c_sub_switch: cover property (@(posedge clk) disable iff (!rst_b)
    r.active_sel == `SCPMC_SEL_SUB);
endmodule : scpmc_ctrl
`default_nettype wire

// >>> hw/scpmc_pkg.sv
`default_nettype none
package scpmc_pkg;
  // Power modes, codes as read back in the status register
  typedef enum logic [2:0] {
    SCPMC_RUN = 3'h0,
    SCPMC_SLEEP = 3'h1,
    SCPMC_IDLE_MODE_0 = 3'h2,
    SCPMC_IDLE_MODE_1 = 3'h3,
    SCPMC_IDLE_MODE_2 = 3'h4
  } scpmc_mode_type;

  // Bus address-phase capture
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } scpmc_aphase_type;

  // Whole block state
  typedef struct packed {
    scpmc_aphase_type ap;
    logic [2:0] sys_clk_select;
    logic fast_osc_halt_keep;
    logic slow_osc_halt_keep;
    logic [1:0] fast_osc_freq_sel;
    logic [1:0] applied_freq;
    logic fast_osc_enable;
    logic fast_osc_stable_flag;
    logic slow_stable;
    logic [15:0] fast_cnt;
    logic [15:0] slow_cnt;
    logic power_down_flag;
    logic timeout_flag;
    logic [7:0] porta_wake_mask;
    logic [7:0] pa_s1;
    logic [7:0] pa_s2;
    logic [7:0] pa_prev;
    logic [7:0] irq_masked;
    scpmc_mode_type mode;
    logic [2:0] active_sel;
    logic [5:0] div_cnt;
    logic sys_tick;
    logic wake_resume;
    logic wake_irq_service;
    logic wake_wdt_reset;
    logic wdt_clear;
  } scpmc_state_type;
endpackage : scpmc_pkg
`default_nettype wire

// >>> sim/scpmc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Processor core stand-in
// ----------------------------------------
module scpmc_core_model (
  input wire logic clk,
  output logic halt_exec,
  output logic clr_wdt_exec,
  output logic wdt_overflow
);
  // Quiet at time zero so no stray halt lands on reset release
  initial begin
    halt_exec = 1'b0;
    clr_wdt_exec = 1'b0;
    wdt_overflow = 1'b0;
  end

  // One-cycle strobe set: bit2 overflow, bit1 clear-watchdog, bit0 halt
  task automatic fire(input logic [2:0] s);
    {wdt_overflow, clr_wdt_exec, halt_exec} <= s;
    @(posedge clk);
    {wdt_overflow, clr_wdt_exec, halt_exec} <= 3'h0;
  endtask : fire
endmodule : scpmc_core_model
`default_nettype wire

// >>> sim/system_clock_and_power_mode_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "scpmc_consts.svh"
module system_clock_and_power_mode_control_test;
  localparam logic [7:0] A_SCC = `SCPMC_ADDR_SYS_CLK_CTRL;
  localparam logic [7:0] A_FOC = `SCPMC_ADDR_FAST_OSC_CTRL;
  localparam logic [7:0] A_PST = `SCPMC_ADDR_POWER_STATUS;
  localparam logic [7:0] A_PAW = `SCPMC_ADDR_PORTA_WAKE;
  logic clk, rst_b, hsel, hwrite, hreadyout, hresp, stack_full;
  logic halt_exec, clr_wdt_exec, wdt_overflow, cpu_halted, wdt_clear;
  logic sys_clk_tick, fast_osc_run, slow_osc_run, wake_resume, wake_irq_service, wake_wdt_reset;
  logic [7:0] haddr, porta_pins, irq_req, irq_enable;
  logic [1:0] htrans, fast_osc_freq;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [3:0] seen;
  logic seen_clr;
  logic [1:0] kp [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  logic [2:0] md [4] = '{scpmc_pkg::SCPMC_SLEEP, scpmc_pkg::SCPMC_IDLE_MODE_0, scpmc_pkg::SCPMC_IDLE_MODE_1,
                         scpmc_pkg::SCPMC_IDLE_MODE_2};
  logic [2:0] wx [4] = '{3'b100, 3'b010, 3'b001, 3'b001};
  logic [1:0] fq [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  logic [1:0] fa [4] = '{2'h1, 2'h2, 2'h0, 2'h0};
  int mismatches = 0, checks = 0, cyc = 0, ticks, n;

  scpmc_ctrl #(.PA_WIDTH(8), .IRQ_WIDTH(8)) dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .halt_exec(halt_exec),
    .clr_wdt_exec(clr_wdt_exec), .wdt_overflow(wdt_overflow), .porta_pins(porta_pins),
    .irq_req(irq_req), .irq_enable(irq_enable), .stack_full(stack_full), .sys_clk_tick(sys_clk_tick),
    .fast_osc_run(fast_osc_run), .slow_osc_run(slow_osc_run), .fast_osc_freq(fast_osc_freq),
    .cpu_halted(cpu_halted), .wdt_clear(wdt_clear), .wake_resume(wake_resume),
    .wake_irq_service(wake_irq_service), .wake_wdt_reset(wake_wdt_reset));
  scpmc_core_model core (.clk(clk), .halt_exec(halt_exec), .clr_wdt_exec(clr_wdt_exec),
    .wdt_overflow(wdt_overflow));

  // ----------------------------------------
  // Clock, pulse catcher, hang guard
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Wake pulses last one cycle, so hold them until the bench looks
  always @(posedge clk) begin
    seen <= seen_clr ? 4'h0 : (seen | {wdt_clear, wake_wdt_reset, wake_irq_service, wake_resume});
  end
  // Guard far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      mismatches++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // Single word transfer; the slave sets the pace through hreadyout
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    {hsel, hwrite, htrans, hsize} <= {1'b1, w, 2'h2, 3'h2};
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    {hsel, htrans} <= 3'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  // Software waits for the fast oscillator before trusting it
  task automatic poll_stable();
    n = 0;
    do begin
      bus(1'b0, A_FOC, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 250);
  endtask : poll_stable

  task automatic stop_test();
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_b, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {irq_req, irq_enable, stack_full, seen_clr} = '0;
    porta_pins = 8'hFF;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(1'b0, A_SCC, 32'h0); chk(rd, 32'h0);
    bus(1'b0, A_FOC, 32'h0); chk(rd, 32'h1);
    bus(1'b1, 8'h10, 32'hFF);
    bus(1'b0, 8'h10, 32'h0); chk(rd, 32'h0);
    poll_stable(); chk(rd, 32'h3);
    // Each new code waits for the stable flag before it applies
    for (int f = 0; f < 4; f++) begin
      bus(1'b1, A_FOC, {28'h0, fq[f], 2'b01});
      bus(1'b0, A_FOC, 32'h0); chk(rd, {28'h0, fq[f], 2'b01});
      chk(32'(fast_osc_freq), f == 0 ? 32'h0 : 32'(fa[f-1]));
      poll_stable();
      repeat (2) @(posedge clk);
      chk(32'(fast_osc_freq), 32'(fa[f]));
    end
    bus(1'b1, A_FOC, 32'h0);
    bus(1'b1, A_FOC, 32'h1);
    bus(1'b0, A_FOC, 32'h0); chk(rd, 32'h1);
    poll_stable();
    // Divider: ticks in a 128-cycle window, sampled off the edge
    for (int c = 0; c < 7; c++) begin
      bus(1'b1, A_SCC, 32'(c << 5));
      repeat (140) @(posedge clk);
      ticks = 0;
      repeat (128) begin
        @(negedge clk);
        ticks += int'(sys_clk_tick === 1'b1);
      end
      @(posedge clk);
      chk(ticks, 128 >> c);
    end
    bus(1'b1, A_SCC, 32'hE0);
    bus(1'b1, A_FOC, 32'h0);
    n = 0;
    while (fast_osc_run !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(32'(fast_osc_run), 32'h0);
    bus(1'b0, A_SCC, 32'h0); chk(rd, 32'hE0);
    bus(1'b1, A_FOC, 32'h1);
    poll_stable(); chk(32'(fast_osc_run), 32'h1);
    bus(1'b1, A_SCC, 32'h0);
    bus(1'b1, A_PAW, 32'h4);
    // Halt under each keep setting, woken by watchdog, interrupt (serviced, then deferred by stack full) or port edge
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, A_SCC, {30'h0, kp[k]});
      irq_req <= k == 2 ? 8'h01 : 8'h00;
      irq_enable <= k == 1 || k == 2 ? 8'h02 : 8'h00;
      stack_full <= k == 2;
      seen_clr <= 1'b1;
      @(posedge clk);
      seen_clr <= 1'b0;
      core.fire(3'h1);
      @(negedge clk); chk(32'({cpu_halted, wdt_clear}), 32'h3);
      @(posedge clk); chk(32'({fast_osc_run, slow_osc_run}), 32'(kp[k]));
      bus(1'b0, A_PST, 32'h0); chk(rd, {25'h0, md[k], 4'h1});
      repeat (20) @(posedge clk);
      chk(32'(cpu_halted), 32'h1);
      if (k == 0) core.fire(3'h4);
      else if (k == 3) porta_pins <= 8'hFB;
      else irq_req <= irq_req | 8'h02;
      n = 0;
      while (cpu_halted !== 1'b0 && n < 20) begin
        @(negedge clk);
        n++;
      end
      @(negedge clk); chk(32'(seen[2:0]), 32'(wx[k]));
      @(posedge clk);
      {irq_req, irq_enable, stack_full} <= '0;
      porta_pins <= 8'hFF;
      bus(1'b0, A_SCC, 32'h0); chk(rd, {30'h0, kp[k]});
      bus(1'b0, A_PST, 32'h0); chk(rd, k == 0 ? 32'h3 : 32'h1);
      core.fire(3'h2);
      bus(1'b0, A_PST, 32'h0); chk(32'(rd[0]), 32'h0);
    end
    stop_test();
  end
endmodule : system_clock_and_power_mode_control_test
`default_nettype wire
